//--- alu_mul_unit.sv
`timescale 1ns/1ps
`default_nettype none

//==============================================================
// shared types and constants
package alu_pkg;

  localparam int          CYC_SINGLE = 1;      // one-cycle operations
  localparam int          CYC_DOUBLE = 2;      // word and product operations
  localparam int          WORD_K_W   = 6;      // width of the word immediate
  localparam logic [7:0]  BYTE_ONES  = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [7:0]  INC_OVF    = 8'h80;  // increment overflow result
  localparam logic [7:0]  DEC_OVF    = 8'h7F;  // decrement overflow result
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  typedef enum logic [4:0] {
    opAdd, opAddCarry, opWordAddImmediate, opSub, opMinusConstant,
    opDifferenceWithBorrow, opDifferenceWithBorrowConstant, opWordMinusImmediate,
    opAnd, opConjunctionWithConstant, opOr, opDisjunctionWithConstant,
    opExclusiveDisjunction, opInvertBits, opTwosInverse, opSetSelectedBits,
    opClearSelectedBits, opIncrement, opMinusOne, opZeroOrMinusCheck,
    opZeroRegister, opAllOnesRegister, opProductUnsigned, opProductSigned
  } aluOp_e;

  typedef enum logic [1:0] {destByte, destWord, destProductPair} dest_e;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } sreg_s;

  localparam sreg_s FLAGS_RESET = '0;

  typedef struct packed {
    aluOp_e      op;
    logic [7:0]  rd;    // destination operand
    logic [7:0]  rr;    // source register or constant
    logic [15:0] word;  // register pair for word operations
  } aluReq_s;

  typedef struct packed {
    dest_e       dest;
    logic [15:0] data;
  } aluRes_s;

  typedef struct packed {
    logic [7:0] r;
    logic       h;
    logic       v;
    logic       c;
  } arith_s;

  // byte addition with carry in and flag terms
  function automatic arith_s addByte(logic [7:0] a, logic [7:0] b, logic cin);
    arith_s x;
    x.r = 8'(a + b + {7'h00, cin});
    x.h = (a[3] & b[3]) | (b[3] & ~x.r[3]) | (~x.r[3] & a[3]);
    x.c = (a[7] & b[7]) | (b[7] & ~x.r[7]) | (~x.r[7] & a[7]);
    x.v = (a[7] & b[7] & ~x.r[7]) | (~a[7] & ~b[7] & x.r[7]);
    return x;
  endfunction

  // byte subtraction with borrow in and flag terms
  function automatic arith_s subByte(logic [7:0] a, logic [7:0] b, logic bin);
    arith_s x;
    x.r = 8'(a - b - {7'h00, bin});
    x.h = (~a[3] & b[3]) | (b[3] & x.r[3]) | (x.r[3] & ~a[3]);
    x.c = (~a[7] & b[7]) | (b[7] & x.r[7]) | (x.r[7] & ~a[7]);
    x.v = (a[7] & ~b[7] & ~x.r[7]) | (~a[7] & b[7] & x.r[7]);
    return x;
  endfunction

endpackage

//==============================================================
// registered multiplier stage
module alu_mul_unit #(
  parameter int WIDTH = 8
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic               signedMode,
  input  wire logic [WIDTH-1:0]   opA,
  input  wire logic [WIDTH-1:0]   opB,
  output logic                    prodValid,
  output logic [2*WIDTH-1:0]      product
);

  // refuse widths the product register cannot serve
  if (WIDTH < 2) begin
    $error("multiplier width too small");
  end

  logic [2*WIDTH-1:0] prodU;
  logic [2*WIDTH-1:0] prodS;

  // both products, chosen by mode
  assign prodU = {{WIDTH{1'b0}}, opA} * {{WIDTH{1'b0}}, opB};
  assign prodS = $unsigned({{WIDTH{opA[WIDTH-1]}}, opA} * {{WIDTH{opB[WIDTH-1]}}, opB});

  // product register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      product   <= '0;
      prodValid <= 1'b0;
    end else begin
      prodValid <= start;
      if (start) begin
        product <= signedMode ? prodS : prodU;
      end
    end
  end

endmodule

`default_nettype wire

//--- eight_bit_alu_datapath.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - add, add carry: sum, ZCNVH, 1 cycle
// RQ2 - word add immediate: ZCNVS, 2 cycles
// RQ3 - subtract register or constant: ZCNVH, 1 cycle
// RQ4 - register minus source minus carry, 1 cycle
// RQ5 - register minus constant minus carry, 1 cycle
// RQ6 - word minus immediate: ZCNVS, 2 cycles
// RQ7 - AND register or constant: ZNV, 1 cycle
// RQ8 - OR register or constant: ZNV, 1 cycle
// RQ9 - exclusive OR registers: ZNV, 1 cycle
// RQ10 - invert FF-Rd, negate 00-Rd, 1 cycle
// RQ11 - set bits: OR mask, ZNV
// RQ12 - clear bits: AND FF minus mask
// RQ13 - increment: ZNV, carry kept
// RQ14 - decrement: ZNV, carry kept
// RQ15 - test: value unchanged, ZNV
// RQ16 - clear via XOR; set loads FF, no flags
// RQ17 - multiplies: product to R1:R0, ZC, 2 cycles
// RQ18 - unlisted flags keep previous value
module eight_bit_alu_datapath
  import alu_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    reqValid,
  output logic         reqReady,
  input  wire aluReq_s req,
  output logic         resValid,
  output aluRes_s      res,
  output sreg_s        flags
);

  //==============================================================
  // state
  logic    pendFf;      // second cycle of a two-cycle operation
  aluOp_e  holdOpFf;
  logic [15:0] holdWordFf;
  sreg_s   holdFlagsFf;
  aluRes_s resFf;
  logic    resValidFf;
  sreg_s   flagsFf;

  logic    accept;
  logic    isDouble;
  logic    isProduct;
  arith_s  ar;
  logic [7:0]  logicR;
  logic [15:0] wordR;
  logic [15:0] wordK;
  aluRes_s nxt_res;
  sreg_s   nxt_flags;
  logic        prodValid;
  logic [15:0] product;

  assign reqReady  = ~pendFf;
  assign accept    = reqValid & reqReady;
  assign isProduct = (req.op == opProductUnsigned) | (req.op == opProductSigned);
  assign isDouble  = isProduct | (req.op == opWordAddImmediate)
                   | (req.op == opWordMinusImmediate);
  assign wordK     = {{(16 - WORD_K_W){1'b0}}, req.rr[WORD_K_W-1:0]};

  // multiplier, result taken in the second cycle
  alu_mul_unit #(
    .WIDTH (8)
  ) u_mul (
    .clk        (clk),
    .rst        (rst),
    .start      (accept & isProduct),
    .signedMode (req.op == opProductSigned),
    .opA        (req.rd),
    .opB        (req.rr),
    .prodValid  (prodValid),
    .product    (product)
  );

  //==============================================================
  // byte arithmetic selection
  always_comb begin
    case (req.op)
      opAdd:                          ar = addByte(req.rd, req.rr, 1'b0);    // see RQ1
      opAddCarry:                     ar = addByte(req.rd, req.rr, flagsFf.c); // see RQ1
      opSub, opMinusConstant:         ar = subByte(req.rd, req.rr, 1'b0);    // see RQ3
      opDifferenceWithBorrow:         ar = subByte(req.rd, req.rr, flagsFf.c); // see RQ4
      opDifferenceWithBorrowConstant: ar = subByte(req.rd, req.rr, flagsFf.c); // see RQ5
      opTwosInverse:                  ar = subByte(BYTE_ZERO, req.rd, 1'b0); // see RQ10
      opIncrement:                    ar = addByte(req.rd, BYTE_ONE, 1'b0);  // see RQ13
      opMinusOne:                     ar = subByte(req.rd, BYTE_ONE, 1'b0);  // see RQ14
      default:                        ar = addByte(req.rd, req.rr, 1'b0);
    endcase
  end

  // logic results
  always_comb begin
    case (req.op)
      opAnd, opConjunctionWithConstant: logicR = req.rd & req.rr;             // see RQ7
      opOr, opDisjunctionWithConstant:  logicR = req.rd | req.rr;             // see RQ8
      opExclusiveDisjunction:           logicR = req.rd ^ req.rr;             // see RQ9
      opInvertBits:                     logicR = BYTE_ONES - req.rd;          // see RQ10
      opSetSelectedBits:                logicR = req.rd | req.rr;             // see RQ11
      opClearSelectedBits:              logicR = req.rd & (BYTE_ONES - req.rr); // see RQ12
      opZeroOrMinusCheck:               logicR = req.rd & req.rd;             // see RQ15
      opZeroRegister:                   logicR = req.rd ^ req.rd;             // see RQ16
      opAllOnesRegister:                logicR = BYTE_ONES;                   // see RQ16
      default:                          logicR = req.rd;
    endcase
  end

  // word add or subtract
  assign wordR = (req.op == opWordMinusImmediate) ? 16'(req.word - wordK)
                                                  : 16'(req.word + wordK);

  //==============================================================
  // next result and flags for the accepted operation
  always_comb begin
    nxt_res       = '0;
    nxt_res.dest  = destByte;
    nxt_flags     = flagsFf;                                    // see RQ18
    case (req.op)
      opAdd, opAddCarry, opSub, opMinusConstant, opTwosInverse: begin
        nxt_res.data = {BYTE_ZERO, ar.r};
        nxt_flags.z  = (ar.r == BYTE_ZERO);                     // see RQ1
        nxt_flags.c  = ar.c;
        nxt_flags.n  = ar.r[7];
        nxt_flags.v  = ar.v;
        nxt_flags.h  = ar.h;
      end
      opDifferenceWithBorrow, opDifferenceWithBorrowConstant: begin
        nxt_res.data = {BYTE_ZERO, ar.r};
        nxt_flags.z  = (ar.r == BYTE_ZERO) & flagsFf.z;         // see RQ4
        nxt_flags.c  = ar.c;
        nxt_flags.n  = ar.r[7];
        nxt_flags.v  = ar.v;
        nxt_flags.h  = ar.h;                                    // see RQ5
      end
      opIncrement, opMinusOne: begin
        nxt_res.data = {BYTE_ZERO, ar.r};
        nxt_flags.z  = (ar.r == BYTE_ZERO);
        nxt_flags.n  = ar.r[7];
        nxt_flags.v  = (req.op == opIncrement) ? (ar.r == INC_OVF)  // see RQ13
                                               : (ar.r == DEC_OVF); // see RQ14
      end
      opInvertBits: begin
        nxt_res.data = {BYTE_ZERO, logicR};
        nxt_flags.z  = (logicR == BYTE_ZERO);
        nxt_flags.c  = 1'b1;                                    // see RQ10
        nxt_flags.n  = logicR[7];
        nxt_flags.v  = 1'b0;
      end
      opAllOnesRegister: begin
        nxt_res.data = {BYTE_ZERO, logicR};                     // see RQ16
      end
      opWordAddImmediate: begin
        nxt_res.dest = destWord;
        nxt_res.data = wordR;
        nxt_flags.z  = (wordR == WORD_ZERO);                    // see RQ2
        nxt_flags.n  = wordR[15];
        nxt_flags.v  = ~req.word[15] & wordR[15];
        nxt_flags.c  = ~wordR[15] & req.word[15];
        nxt_flags.s  = wordR[15] ^ (~req.word[15] & wordR[15]);
      end
      opWordMinusImmediate: begin
        nxt_res.dest = destWord;
        nxt_res.data = wordR;
        nxt_flags.z  = (wordR == WORD_ZERO);                    // see RQ6
        nxt_flags.n  = wordR[15];
        nxt_flags.v  = req.word[15] & ~wordR[15];
        nxt_flags.c  = wordR[15] & ~req.word[15];
        nxt_flags.s  = wordR[15] ^ (req.word[15] & ~wordR[15]);
      end
      opProductUnsigned, opProductSigned: begin
        nxt_res.dest = destProductPair;                         // see RQ17
      end
      default: begin
        nxt_res.data = {BYTE_ZERO, logicR};                     // see RQ7
        nxt_flags.z  = (logicR == BYTE_ZERO);
        nxt_flags.n  = logicR[7];
        nxt_flags.v  = 1'b0;
      end
    endcase
  end

  //==============================================================
  // two-cycle sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendFf      <= 1'b0;
      holdOpFf    <= opAdd;
      holdWordFf  <= WORD_ZERO;
      holdFlagsFf <= FLAGS_RESET;
    end else begin
      pendFf <= accept & isDouble;                              // see RQ2
      if (accept & isDouble) begin
        holdOpFf    <= req.op;
        holdWordFf  <= nxt_res.data;
        holdFlagsFf <= nxt_flags;
      end
    end
  end

  // result register and completion pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resFf      <= '0;
      resValidFf <= 1'b0;
    end else begin
      resValidFf <= (accept & ~isDouble) | pendFf;
      if (pendFf) begin
        resFf.dest <= (holdOpFf == opWordAddImmediate || holdOpFf == opWordMinusImmediate)
                      ? destWord : destProductPair;
        resFf.data <= prodValid ? product : holdWordFf;         // see RQ17
      end else if (accept) begin
        resFf <= nxt_res;                                       // see RQ3
      end
    end
  end

  // status flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flagsFf <= FLAGS_RESET;
    end else if (pendFf) begin
      if (prodValid) begin
        flagsFf.z <= (product == WORD_ZERO);                    // see RQ17
        flagsFf.c <= product[15];
      end else begin
        flagsFf <= holdFlagsFf;                                 // see RQ6
      end
    end else if (accept & ~isDouble) begin
      flagsFf <= nxt_flags;                                     // see RQ18
    end
  end

  assign resValid = resValidFf;
  assign res      = resFf;
  assign flags    = flagsFf;

  //==============================================================
  // checks
  sequence acceptSingle;
    accept && !isDouble;
  endsequence

  sequence acceptTwo;
    accept && isDouble;
  endsequence

  single_latency_a: assert property (@(posedge clk) disable iff (rst) // see RQ3
    acceptSingle |=> resValid && reqReady)
    else $error("single cycle operation not done in one cycle");

  double_latency_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
    acceptTwo |=> (!resValid && !reqReady) ##1 resValid)
    else $error("two cycle operation timing wrong");

  add_sum_a: assert property (@(posedge clk) disable iff (rst) // see RQ1
    accept && req.op == opAddCarry |=>
      res.data[7:0] == 8'($past(req.rd) + $past(req.rr) + {7'h00, $past(flags.c)}))
    else $error("add with carry sum wrong");

  borrow_diff_a: assert property (@(posedge clk) disable iff (rst) // see RQ4
    accept && req.op == opDifferenceWithBorrow |=>
      res.data[7:0] == 8'($past(req.rd) - $past(req.rr) - {7'h00, $past(flags.c)}))
    else $error("subtract with borrow wrong");

  borrow_zero_a: assert property (@(posedge clk) disable iff (rst) // see RQ5
    accept && req.op == opDifferenceWithBorrowConstant && !flags.z |=> !flags.z)
    else $error("borrow constant subtract zero flag wrong");

  logic_carry_a: assert property (@(posedge clk) disable iff (rst) // see RQ7
    accept && (req.op == opAnd || req.op == opOr || req.op == opExclusiveDisjunction) |=>
      flags.c == $past(flags.c) && flags.h == $past(flags.h) && !flags.v)
    else $error("logic operation touched carry or half carry");

  invert_flags_a: assert property (@(posedge clk) disable iff (rst) // see RQ10
    accept && req.op == opInvertBits |=> flags.c && res.data[7:0] == ~$past(req.rd))
    else $error("invert result or carry wrong");

  clear_bits_a: assert property (@(posedge clk) disable iff (rst) // see RQ12
    accept && req.op == opClearSelectedBits |=>
      res.data[7:0] == ($past(req.rd) & ~$past(req.rr)))
    else $error("clear bits result wrong");

  count_carry_a: assert property (@(posedge clk) disable iff (rst) // see RQ13
    accept && (req.op == opIncrement || req.op == opMinusOne) |=>
      flags.c == $past(flags.c))
    else $error("increment or decrement changed carry");

  all_ones_a: assert property (@(posedge clk) disable iff (rst) // see RQ16
    accept && req.op == opAllOnesRegister |=> $stable(flags) && res.data[7:0] == BYTE_ONES)
    else $error("set register wrong");

  product_dest_a: assert property (@(posedge clk) disable iff (rst) // see RQ17
    accept && req.op == opProductUnsigned |=> ##1
      res.dest == destProductPair &&
      res.data == 16'({8'h00, $past(req.rd, 2)} * {8'h00, $past(req.rr, 2)}))
    else $error("unsigned product wrong");

  word_sub_a: assert property (@(posedge clk) disable iff (rst) // see RQ6
    accept && req.op == opWordMinusImmediate |=> ##1
      res.data == 16'($past(req.word, 2) - {10'h000, $past(req.rr[WORD_K_W-1:0], 2)}))
    else $error("word subtract wrong");

endmodule

`default_nettype wire

//--- test_eight_bit_alu_datapath.sv
`timescale 1ns/1ps
`default_nettype none

module test_eight_bit_alu_datapath
  import alu_pkg::*;
;
  //==============================================================
  // stimulus and observation
  logic    clk      = 1'b0;
  logic    rst      = 1'b1;
  logic    reqValid = 1'b0;
  logic    reqReady;
  aluReq_s req      = '0;
  logic    resValid;
  aluRes_s res;
  sreg_s   flags;
  sreg_s   model    = FLAGS_RESET;
  int      failures = 0;
  int      compares = 0;

  // 10 MHz core clock
  always #50 clk = ~clk;

  eight_bit_alu_datapath DUT (
    .clk      (clk),
    .rst      (rst),
    .reqValid (reqValid),
    .reqReady (reqReady),
    .req      (req),
    .resValid (resValid),
    .res      (res),
    .flags    (flags)
  );

  //==============================================================
  // shared helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // observed result against the flag model
  task automatic result(input dest_e d, input logic [15:0] data);
    check("resValid", {15'h0000, resValid}, 16'h0001);
    check("dest", {14'h0000, res.dest}, {14'h0000, d});
    check("data", res.data, data);
    check("flags", {10'h000, flags}, {10'h000, model});
  endtask

  // one request, offered for one cycle with reqReady checked, then the answer at its fixed latency
  task automatic exec(input aluOp_e op, input logic [7:0] a, input logic [7:0] b,
                      input logic [15:0] w, input dest_e d, input logic [15:0] data,
                      input int lat);
    @(posedge clk);
    reqValid <= 1'b1;
    req      <= '{op: op, rd: a, rr: b, word: w};
    @(negedge clk);
    check("reqReady", {15'h0000, reqReady}, 16'h0001);
    @(posedge clk);
    reqValid <= 1'b0;
    if (lat == CYC_DOUBLE) begin
      @(negedge clk);
      check("busy", {14'h0000, reqReady, resValid}, 16'h0000);
      @(posedge clk);
    end
    @(negedge clk);
    result(d, data);
    @(negedge clk);
    check("pulse", {15'h0000, resValid}, 16'h0000);
  endtask

  task automatic byteOp(input aluOp_e op, input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] r);
    exec(op, a, b, WORD_ZERO, destByte, {8'h00, r}, CYC_SINGLE);
  endtask

  // byte add or subtract, updating z n v c h of the model
  task automatic arith(input logic [7:0] a, input logic [7:0] b, input logic ci,
                       input logic sub, output logic [7:0] r);
    logic [8:0] f;
    logic [4:0] lo;
    f  = sub ? {1'b0, a} - {1'b0, b} - {8'h00, ci} : {1'b0, a} + {1'b0, b} + {8'h00, ci};
    lo = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci}
             : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    r       = f[7:0];
    model.c = f[8];
    model.h = lo[4];
    model.v = sub ? (a[7] != b[7]) && (r[7] != a[7]) : (a[7] == b[7]) && (r[7] != a[7]);
    model.n = r[7];
    model.z = (r == BYTE_ZERO);
  endtask

  // borrow forms chain the zero flag
  task automatic arithOp(input aluOp_e op, input logic [7:0] a, input logic [7:0] b,
                         input logic useC, input logic sub);
    logic [7:0] r;
    logic       z;
    z = model.z;
    arith(a, b, useC & model.c, sub, r);
    if (useC && sub) model.z = model.z & z;
    byteOp(op, a, b, r);
  endtask

  task automatic logicFlags(input logic [7:0] r);
    model.z = (r == BYTE_ZERO);
    model.n = r[7];
    model.v = 1'b0;
  endtask

  //==============================================================
  // scenarios
  task automatic addTests();
    arithOp(opAdd, 8'h3A, 8'h48, 1'b0, 1'b0);
    arithOp(opAddCarry, 8'hFF, 8'h01, 1'b1, 1'b0);
    arithOp(opAddCarry, 8'h10, 8'h20, 1'b1, 1'b0);
    $display("add tests done");
  endtask

  task automatic subTests();
    arithOp(opSub, 8'h10, 8'h20, 1'b0, 1'b1);
    arithOp(opMinusConstant, 8'h80, 8'h01, 1'b0, 1'b1);
    arithOp(opSub, 8'h05, 8'h05, 1'b0, 1'b1);
    arithOp(opDifferenceWithBorrow, 8'h00, 8'h00, 1'b1, 1'b1);
    arithOp(opDifferenceWithBorrow, 8'h00, 8'h01, 1'b1, 1'b1);
    arithOp(opMinusConstant, 8'h01, 8'h02, 1'b0, 1'b1);
    arithOp(opDifferenceWithBorrowConstant, 8'h01, 8'h00, 1'b1, 1'b1);
    arithOp(opDifferenceWithBorrowConstant, 8'h40, 8'h3F, 1'b1, 1'b1);
    $display("subtract tests done");
  endtask

  task automatic wordOp(input logic sub, input logic [15:0] w, input logic [5:0] k);
    logic [15:0] r;
    r       = sub ? w - {10'h000, k} : w + {10'h000, k};
    model.z = (r == WORD_ZERO);
    model.n = r[15];
    model.v = sub ? (w[15] & ~r[15]) : (~w[15] & r[15]);
    model.c = sub ? (r[15] & ~w[15]) : (~r[15] & w[15]);
    model.s = model.n ^ model.v;
    exec(sub ? opWordMinusImmediate : opWordAddImmediate, 8'h00, {2'b00, k}, w,
         destWord, r, CYC_DOUBLE);
  endtask

  task automatic wordTests();
    wordOp(1'b0, 16'h7FFF, 6'h3F);
    wordOp(1'b0, 16'hFFC1, 6'h3F);
    wordOp(1'b1, 16'h0000, 6'h01);
    wordOp(1'b1, 16'h8000, 6'h01);
    $display("word tests done");
  endtask

  task automatic logicTests();
    aluOp_e     ops [9] = '{opAnd, opConjunctionWithConstant, opOr, opDisjunctionWithConstant,
                            opExclusiveDisjunction, opSetSelectedBits, opClearSelectedBits,
                            opZeroOrMinusCheck, opZeroRegister};
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    arithOp(opSub, 8'h00, 8'h01, 1'b0, 1'b1); // carry and half set beforehand
    for (int i = 0; i < 9; i++) begin
      a = 8'hC6;
      b = (i > 6) ? a : 8'h8C;
      case (ops[i])
        opAnd, opConjunctionWithConstant:                    r = a & b;
        opOr, opDisjunctionWithConstant, opSetSelectedBits: r = a | b;
        opExclusiveDisjunction, opZeroRegister:              r = a ^ b;
        opClearSelectedBits:                                 r = a & (BYTE_ONES - b);
        default:                                             r = a & a;
      endcase
      logicFlags(r);
      byteOp(ops[i], a, b, r);
    end
    byteOp(opAllOnesRegister, 8'h12, 8'h00, BYTE_ONES);
    $display("logic tests done");
  endtask

  task automatic twos(input logic [7:0] a);
    logic [7:0] r;
    arith(BYTE_ZERO, a, 1'b0, 1'b1, r);
    byteOp(opTwosInverse, a, 8'h00, r);
  endtask

  task automatic incDec(input aluOp_e op, input logic [7:0] a, input logic [7:0] r,
                        input logic [7:0] ovf);
    logicFlags(r);
    model.v = (r == ovf);
    byteOp(op, a, 8'h00, r);
  endtask

  task automatic unaryTests();
    logicFlags(8'hAA);
    model.c = 1'b1;
    byteOp(opInvertBits, 8'h55, 8'h00, 8'hAA);
    twos(8'h00);
    twos(8'h80);
    twos(8'h01);
    incDec(opIncrement, 8'hFF, 8'h00, INC_OVF);
    incDec(opIncrement, 8'h7F, 8'h80, INC_OVF);
    incDec(opMinusOne, 8'h80, 8'h7F, DEC_OVF);
    incDec(opMinusOne, 8'h01, 8'h00, DEC_OVF);
    $display("unary tests done");
  endtask

  task automatic mulOp(input logic sgn, input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    p       = sgn ? {{8{a[7]}}, a} * {{8{b[7]}}, b} : {8'h00, a} * {8'h00, b};
    model.z = (p == WORD_ZERO);
    model.c = p[15];
    exec(sgn ? opProductSigned : opProductUnsigned, a, b, WORD_ZERO, destProductPair, p,
         CYC_DOUBLE);
  endtask

  task automatic mulTests();
    mulOp(1'b0, 8'hFF, 8'hFF);
    mulOp(1'b0, 8'h00, 8'h12);
    mulOp(1'b1, 8'hFF, 8'hFF);
    mulOp(1'b1, 8'h80, 8'h01);
    $display("multiply tests done");
  endtask

  // a held request is refused behind a word op, then byte ops run back to back
  task automatic stream();
    @(posedge clk);
    reqValid <= 1'b1;
    req      <= '{op: opWordAddImmediate, rd: 8'h00, rr: 8'h01, word: 16'h00FF};
    @(posedge clk);
    req      <= '{op: opIncrement, rd: 8'h7F, rr: 8'h00, word: WORD_ZERO};
    @(negedge clk);
    check("refused", {15'h0000, reqReady}, 16'h0000);
    @(posedge clk);
    @(negedge clk);
    model = '{h: model.h, s: 1'b0, v: 1'b0, n: 1'b0, z: 1'b0, c: 1'b0};
    result(destWord, 16'h0100);
    @(posedge clk);
    req <= '{op: opMinusOne, rd: 8'h80, rr: 8'h00, word: WORD_ZERO};
    @(negedge clk);
    logicFlags(8'h80);
    model.v = 1'b1;
    result(destByte, 16'h0080);
    @(posedge clk);
    reqValid <= 1'b0;
    @(negedge clk);
    model.n = 1'b0;
    result(destByte, 16'h007F);
    $display("stream test done");
  endtask

  //==============================================================
  // verdict and run control
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset", {8'h00, reqReady, resValid, flags}, 16'h0080);
    @(posedge clk);
    rst <= 1'b0;
    addTests();
    subTests();
    wordTests();
    logicTests();
    unaryTests();
    mulTests();
    stream();
    conclude();
  end

endmodule

`default_nettype wire
